// file: hdl/lmcs_pkg.sv
/*
 Package for the laser modulation compensation and safety block: register
 offsets, field positions, reset values, timing counts and carrier structs.
 Assumes a 125 MHz system clock.
*/
package lmcs_pkg;
    localparam int LMCS_AW = 4;
    localparam int LMCS_DW = 16;
    localparam int LMCS_TW = 12;
    // Register indices (word offsets)
    localparam logic [3:0] LMCS_OFS_MOD_TARGET = 4'h0;
    localparam logic [3:0] LMCS_OFS_MOD_CEIL = 4'h1;
    localparam logic [3:0] LMCS_OFS_BIAS_REF = 4'h2;
    localparam logic [3:0] LMCS_OFS_BIAS_GAIN = 4'h3;
    localparam logic [3:0] LMCS_OFS_KNEE = 4'h4;
    localparam logic [3:0] LMCS_OFS_SLOPE = 4'h5;
    localparam logic [3:0] LMCS_OFS_FW_COEF = 4'h6;
    localparam logic [3:0] LMCS_OFS_COMP_CTL = 4'h7;
    localparam logic [3:0] LMCS_OFS_LD_CTL0 = 4'h8;
    localparam logic [3:0] LMCS_OFS_LD_CTL1 = 4'h9;
    localparam logic [3:0] LMCS_OFS_DAC = 4'ha;
    localparam logic [3:0] LMCS_OFS_STATUS = 4'hb;
    localparam logic [3:0] LMCS_OFS_PWR_MON = 4'hc;
    localparam logic [3:0] LMCS_OFS_BIAS_READING = 4'hd;
    localparam logic [3:0] LMCS_OFS_MOD_READING = 4'he;
    localparam logic [3:0] LMCS_OFS_TEMP_MON = 4'hf;
    // Compensation control fields
    localparam int LMCS_BIT_BIAS_EN = 0;
    localparam int LMCS_BIT_TEMP_EN = 1;
    localparam int LMCS_BIT_TEMP_SEL = 2;
    localparam int LMCS_BIT_FW_EN = 3;
    localparam logic [15:0] LMCS_RST_COMP_CTL = 16'h0002;
    // Control register 0/1 fields
    localparam int LMCS_BIT_SOFT_OFF = 0;
    localparam int LMCS_BIT_BYPASS = 1;
    localparam int LMCS_BIT_FAULT_CLR = 0;
    localparam int LMCS_BIT_NOLATCH = 1;
    // Slope exponent range
    localparam logic signed [4:0] LMCS_EXP_MIN = -5'sd12;
    localparam logic signed [4:0] LMCS_EXP_MAX = 5'sd11;
    // Detector count: supply, anode, cathode, photodiode, data output
    localparam int LMCS_NDET = 5;
    // Timing
    localparam int LMCS_CLK_KHZ = 125000;
    localparam int LMCS_ONESHOT_US = 3000;
    localparam int LMCS_ONESHOT_CYC = LMCS_ONESHOT_US * LMCS_CLK_KHZ / 1000;
    localparam int LMCS_SAMPLE_CYC = 256;
    localparam logic [15:0] LMCS_RST_CEIL = 16'h0fff;

    typedef struct packed {
        logic [LMCS_TW-1:0] pwr;
        logic [LMCS_TW-1:0] bias;
        logic [LMCS_TW-1:0] modm;
        logic [LMCS_TW-1:0] temp_int;
        logic [LMCS_TW-1:0] temp_ext;
    } lmcs_adc_s;

    typedef struct packed {
        logic laser_on;
        logic supply_closed;
        logic tx_fault;
    } lmcs_safe_s;
endpackage

// file: hdl/lmcs_top.sv
/*
 Modulation DAC computation with bias or thermal compensation, and the laser
 safety logic. Assumes converter readings are synchronous to clk; detector
 flags, the disable pin and the bias-settled flag are asynchronous pins.
*/
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
module lmcs_top
    import lmcs_pkg::*;
#(
    parameter int ONESHOT_CYC = LMCS_ONESHOT_CYC,
    parameter int SAMPLE_CYC = LMCS_SAMPLE_CYC
)(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [LMCS_AW-1:0] addr,
    input wire logic [LMCS_DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [LMCS_DW-1:0] rdata,
    // Converter readings
    input wire lmcs_adc_s adc,
    // Pins
    input wire logic tx_dis,
    input wire logic [LMCS_NDET-1:0] det_fault,
    input wire logic bias_settled,
    // Laser controls
    output logic [LMCS_TW-1:0] mod_dac_value,
    output logic laser_on,
    output logic laser_supply_switch,
    output logic tx_fault
);
    typedef enum logic [1:0] {
        LMCS_ST_OFF = 2'b00,
        LMCS_ST_CHECK = 2'b01,
        LMCS_ST_SETTLE = 2'b10,
        LMCS_ST_RUN = 2'b11
    } lmcs_state_e;

    logic [15:0] mod_target_reg, mod_ceiling_reg, bias_reference_reg, gain_reg;
    logic [15:0] knee_reg, slope_reg, fw_coef_reg, comp_ctl_reg, ctl0_reg;
    logic [1:0] ctl1_reg;
    logic [LMCS_NDET-1:0] diag_reg;
    logic fault_latch_reg;
    lmcs_state_e state_reg;
    logic [31:0] shot_reg;
    logic [15:0] samp_reg;
    logic [LMCS_TW-1:0] bias_sample_reg;
    logic [LMCS_NDET+1:0] sync1_reg, sync2_reg;
    logic dis_prev_reg;
    logic clr_pulse;

    // Pin synchronisers
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            // Idle levels: disabled, unsettled, no detector fault
            sync1_reg <= {1'b1, 1'b0, {LMCS_NDET{1'b0}}};
            sync2_reg <= {1'b1, 1'b0, {LMCS_NDET{1'b0}}};
        end
        else if (ce)
        begin
            sync1_reg <= {tx_dis, bias_settled, det_fault};
            sync2_reg <= sync1_reg;
        end

    logic dis_s, settled_s;
    logic [LMCS_NDET-1:0] det_s;
    assign det_s = sync2_reg[LMCS_NDET-1:0];
    assign settled_s = sync2_reg[LMCS_NDET];
    assign dis_s = sync2_reg[LMCS_NDET+1];

    logic soft_off, bypass, nolatch, disabled, dis_fall, any_det, toggle;
    assign soft_off = ctl0_reg[LMCS_BIT_SOFT_OFF];
    assign bypass = ctl0_reg[LMCS_BIT_BYPASS];
    assign nolatch = ctl1_reg[LMCS_BIT_NOLATCH];
    assign disabled = dis_s | soft_off;
    assign any_det = |det_s;
    // Either disable source ends the latch
    assign dis_fall = dis_prev_reg & ~disabled;
    assign toggle = disabled;

    // Register writes
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            mod_target_reg <= 16'h0000;
            mod_ceiling_reg <= LMCS_RST_CEIL;
            bias_reference_reg <= 16'h0000;
            gain_reg <= 16'h0000;
            knee_reg <= 16'h0000;
            slope_reg <= 16'h0000;
            fw_coef_reg <= 16'h0000;
            comp_ctl_reg <= LMCS_RST_COMP_CTL;
            ctl0_reg <= 16'h0000;
            ctl1_reg <= 2'h0;
        end
        else if (ce && wr)
        begin
            unique case (addr)
                LMCS_OFS_MOD_TARGET: mod_target_reg <= wdata;
                LMCS_OFS_MOD_CEIL: mod_ceiling_reg <= wdata;
                LMCS_OFS_BIAS_REF: bias_reference_reg <= wdata;
                LMCS_OFS_BIAS_GAIN: gain_reg <= wdata;
                LMCS_OFS_KNEE: knee_reg <= wdata;
                LMCS_OFS_SLOPE: slope_reg <= wdata;
                LMCS_OFS_FW_COEF: fw_coef_reg <= wdata;
                LMCS_OFS_COMP_CTL: comp_ctl_reg <= wdata;
                LMCS_OFS_LD_CTL0: ctl0_reg <= wdata;
                LMCS_OFS_LD_CTL1: ctl1_reg <= {wdata[LMCS_BIT_NOLATCH], 1'b0};
                default: ;
            endcase
        end

    // Fault clear is a self-clearing write pulse
    assign clr_pulse = ce & wr & (addr == LMCS_OFS_LD_CTL1) & wdata[LMCS_BIT_FAULT_CLR];

    // Read port
    always_ff @(posedge clk or posedge rst)
        if (rst)
            rdata <= 16'h0000;
        else if (ce)
        begin
            rdata <= 16'h0000;
            if (rd)
            begin
                unique case (addr)
                    LMCS_OFS_MOD_TARGET: rdata <= mod_target_reg;
                    LMCS_OFS_MOD_CEIL: rdata <= mod_ceiling_reg;
                    LMCS_OFS_BIAS_REF: rdata <= bias_reference_reg;
                    LMCS_OFS_BIAS_GAIN: rdata <= gain_reg;
                    LMCS_OFS_KNEE: rdata <= knee_reg;
                    LMCS_OFS_SLOPE: rdata <= slope_reg;
                    LMCS_OFS_FW_COEF: rdata <= fw_coef_reg;
                    LMCS_OFS_COMP_CTL: rdata <= comp_ctl_reg;
                    LMCS_OFS_LD_CTL0: rdata <= ctl0_reg;
                    LMCS_OFS_LD_CTL1: rdata <= {14'h0, ctl1_reg};
                    LMCS_OFS_DAC: rdata <= {4'h0, mod_dac_value};
                    LMCS_OFS_STATUS: rdata <= {8'h0, state_reg, fault_latch_reg, diag_reg};
                    LMCS_OFS_PWR_MON: rdata <= {4'h0, adc.pwr};
                    LMCS_OFS_BIAS_READING: rdata <= {4'h0, adc.bias};
                    LMCS_OFS_MOD_READING: rdata <= {4'h0, adc.modm};
                    LMCS_OFS_TEMP_MON: rdata <= {4'h0, comp_ctl_reg[LMCS_BIT_TEMP_SEL] ? adc.temp_ext : adc.temp_int};
                    default: rdata <= 16'h0000;
                endcase
            end
        end

    // Compensation arithmetic
    function automatic logic signed [31:0] lmcs_shift(input logic signed [31:0] v,
                                                      input logic signed [4:0] e);
        logic signed [4:0] c;
        c = (e < LMCS_EXP_MIN) ? LMCS_EXP_MIN : ((e > LMCS_EXP_MAX) ? LMCS_EXP_MAX : e);
        if (c >= 0)
            lmcs_shift = v <<< c;
        else
            lmcs_shift = v >>> (-c);
    endfunction

    function automatic logic [LMCS_TW-1:0] lmcs_sat(input logic signed [31:0] v,
                                                    input logic [15:0] ceil);
        logic signed [31:0] cl;
        cl = $signed({16'h0, ceil});
        if (v < 0)
            lmcs_sat = '0;
        else if (v > cl)
            lmcs_sat = ceil[LMCS_TW-1:0];
        else
            lmcs_sat = v[LMCS_TW-1:0];
    endfunction

    logic [LMCS_TW-1:0] temp_now;
    logic signed [31:0] target_s, temp_term, bias_term, sum;
    logic temp_en, bias_en;
    assign temp_en = comp_ctl_reg[LMCS_BIT_TEMP_EN];
    assign bias_en = comp_ctl_reg[LMCS_BIT_BIAS_EN];
    assign temp_now = comp_ctl_reg[LMCS_BIT_TEMP_SEL] ? adc.temp_ext : adc.temp_int;
    assign target_s = $signed({16'h0, mod_target_reg});
    // Knee minus present temperature, shifted by the slope exponent; fw_coef_reg instead when LMCS_BIT_FW_EN is set
    assign temp_term = comp_ctl_reg[LMCS_BIT_FW_EN] ? $signed({{16{fw_coef_reg[15]}}, fw_coef_reg})
        : lmcs_shift($signed({20'h0, knee_reg[LMCS_TW-1:0]}) - $signed({20'h0, temp_now}),
                     $signed(slope_reg[4:0]));
    assign bias_term = ($signed({20'h0, bias_sample_reg}) - $signed({20'h0, bias_reference_reg[LMCS_TW-1:0]}))
        * $signed({16'h0, gain_reg}) / 32'sd100;
    always_comb
    begin
        if (temp_en)
            sum = target_s + temp_term;
        else if (bias_en)
            sum = target_s + bias_term;
        else
            sum = target_s;
    end

    // Periodic bias sampling
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            samp_reg <= 16'h0000;
            bias_sample_reg <= '0;
        end
        else if (ce)
        begin
            if (samp_reg >= 16'(SAMPLE_CYC - 1))
            begin
                samp_reg <= 16'h0000;
                bias_sample_reg <= adc.bias;
            end
            else
                samp_reg <= samp_reg + 16'h0001;
        end

    always_ff @(posedge clk or posedge rst)
        if (rst)
            mod_dac_value <= '0;
        else if (ce)
            mod_dac_value <= lmcs_sat(sum, mod_ceiling_reg);

    // Safety sequencer
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            state_reg <= LMCS_ST_OFF;
            shot_reg <= 32'h0;
            dis_prev_reg <= 1'b1;
        end
        else if (ce)
        begin
            dis_prev_reg <= disabled;
            unique case (state_reg)
                LMCS_ST_OFF:
                    if (dis_fall)
                        state_reg <= LMCS_ST_CHECK;
                LMCS_ST_CHECK:
                begin
                    shot_reg <= 32'(ONESHOT_CYC - 1);
                    state_reg <= disabled ? LMCS_ST_OFF : LMCS_ST_SETTLE;
                end
                LMCS_ST_SETTLE:
                    if (disabled)
                        state_reg <= LMCS_ST_OFF;
                    else if (shot_reg == 32'h0)
                        state_reg <= LMCS_ST_RUN;
                    else
                        shot_reg <= shot_reg - 32'h1;
                LMCS_ST_RUN:
                    if (disabled)
                        state_reg <= LMCS_ST_OFF;
            endcase
        end

    // Fault latch and diagnostic bits
    logic shot_fail, fault_evt;
    assign shot_fail = (state_reg == LMCS_ST_SETTLE) & (shot_reg == 32'h0) & ~settled_s;
    assign fault_evt = (any_det & ~disabled) | ((state_reg == LMCS_ST_CHECK) & any_det) | shot_fail;
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            fault_latch_reg <= 1'b0;
            diag_reg <= '0;
        end
        else if (ce)
        begin
            if (fault_evt)
                fault_latch_reg <= 1'b1;
            else if (toggle || (bypass && clr_pulse) || nolatch)
                fault_latch_reg <= 1'b0;
            diag_reg <= nolatch ? det_s : (diag_reg & ~{LMCS_NDET{toggle | (bypass & clr_pulse)}}) | det_s;
        end

    // Outputs
    logic fault_now, cut;
    assign fault_now = nolatch ? (any_det | shot_fail) : (fault_latch_reg | fault_evt);
    assign cut = disabled | (fault_now & ~bypass) | (state_reg != LMCS_ST_RUN);
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            tx_fault <= 1'b0;
            laser_on <= 1'b0;
            laser_supply_switch <= 1'b0;
        end
        else if (ce)
        begin
            tx_fault <= fault_now;
            laser_on <= ~cut;
            laser_supply_switch <= ~cut;
        end

    // Checks
    property p_dis_kills;
        @(posedge clk) disable iff (rst) (ce && disabled) |=> !laser_on && !laser_supply_switch;
    endproperty
    a_dis_kills: assert property (p_dis_kills) else $error("laser on while disabled");

    property p_fault_cut;
        @(posedge clk) disable iff (rst) (ce && fault_evt && !bypass) |=> !laser_on;
    endproperty
    a_fault_cut: assert property (p_fault_cut) else $error("fault did not cut laser");

    property p_fault_flag;
        @(posedge clk) disable iff (rst) (ce && fault_evt) |=> tx_fault;
    endproperty
    a_fault_flag: assert property (p_fault_flag) else $error("fault flag missing");

    property p_latch_holds;
        @(posedge clk) disable iff (rst) (fault_latch_reg && !nolatch && !disabled && !clr_pulse && ce)
            |=> fault_latch_reg;
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("fault latch dropped");

    property p_supply_link;
        @(posedge clk) disable iff (rst) laser_supply_switch == laser_on;
    endproperty
    a_supply_link: assert property (p_supply_link) else $error("supply switch mismatch");

    property p_ceiling;
        @(posedge clk) disable iff (rst) mod_dac_value <= mod_ceiling_reg[LMCS_TW-1:0] || mod_dac_value == 0;
    endproperty
    a_ceiling: assert property (p_ceiling) else $error("dac above ceiling");

    sequence s_fall;
        ce && dis_fall && state_reg == LMCS_ST_OFF;
    endsequence
    property p_check_step;
        @(posedge clk) disable iff (rst) s_fall |=> state_reg == LMCS_ST_CHECK;
    endproperty
    a_check_step: assert property (p_check_step) else $error("no pin check on enable");

    property p_run_gated;
        @(posedge clk) disable iff (rst) laser_on |-> $past(state_reg) == LMCS_ST_RUN;
    endproperty
    a_run_gated: assert property (p_run_gated) else $error("laser on before run");

    property p_plain;
        @(posedge clk) disable iff (rst) (ce && !temp_en && !bias_en && mod_target_reg <= mod_ceiling_reg)
            |=> mod_dac_value == $past(mod_target_reg[LMCS_TW-1:0]);
    endproperty
    a_plain: assert property (p_plain) else $error("plain target not passed");

    property p_shot_fail;
        @(posedge clk) disable iff (rst) (ce && shot_fail) |=> fault_latch_reg && tx_fault;
    endproperty
    a_shot_fail: assert property (p_shot_fail) else $error("unsettled bias not latched");

    property p_bypass_run;
        @(posedge clk) disable iff (rst) (ce && bypass && fault_evt && !disabled && state_reg == LMCS_ST_RUN)
            |=> laser_on && tx_fault;
    endproperty
    a_bypass_run: assert property (p_bypass_run) else $error("bypass fault cut laser");

    property p_bypass_clear;
        @(posedge clk) disable iff (rst) (bypass && clr_pulse && !fault_evt && !nolatch) |=> !fault_latch_reg;
    endproperty
    a_bypass_clear: assert property (p_bypass_clear) else $error("fault clear ignored");

    property p_follow;
        @(posedge clk) disable iff (rst) (ce && nolatch && !any_det && !shot_fail) |=> !tx_fault;
    endproperty
    a_follow: assert property (p_follow) else $error("fault flag held without fault");
endmodule // lmcs_top

// file: tb/lmcs_laser_model.sv
/*
 Far-side model: laser, monitor photodiode, temperature sensors and fault
 detectors. Assumes the bench steers levels, injected faults and slow settling.
*/
`timescale 1ns/10ps
module lmcs_laser_model
    import lmcs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Device side
    input wire logic tx_dis,
    input wire logic laser_on,
    input wire logic [LMCS_TW-1:0] mod_dac_value,
    output lmcs_adc_s adc,
    output logic [LMCS_NDET-1:0] det_fault,
    output logic bias_settled,
    // Bench steering
    input wire logic [LMCS_TW-1:0] bias_lvl,
    input wire logic [LMCS_TW-1:0] tint_lvl,
    input wire logic [LMCS_TW-1:0] text_lvl,
    input wire logic [LMCS_NDET-1:0] fault_inj,
    input wire logic slow
);
    logic [3:0] settle_reg;
    // Converter readings
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            adc <= '0;
        else
        begin
            adc.bias <= bias_lvl;
            adc.temp_int <= tint_lvl;
            adc.temp_ext <= text_lvl;
            adc.modm <= laser_on ? mod_dac_value : 12'h000;
            adc.pwr <= laser_on ? {1'b0, bias_lvl[11:1]} : 12'h000;
        end
    end
    // Bias settles a few cycles after enable
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            settle_reg <= 4'h0;
        else if (tx_dis)
            settle_reg <= 4'h0;
        else if (settle_reg != 4'hf)
            settle_reg <= settle_reg + 4'h1;
    end
    assign bias_settled = !slow && (settle_reg >= 4'h6);
    assign det_fault = fault_inj;
endmodule // lmcs_laser_model

// file: tb/lmcs_top_tb.sv
/*
 Self-checking bench for the modulation and safety block.
 Assumes the package constants and the laser model beside it.
*/
`timescale 1ns/10ps
module lmcs_top_tb;
    import lmcs_pkg::*;
    localparam int ONESHOT = 20;
    localparam int T_ON = ONESHOT + 14;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [LMCS_AW-1:0] addr = '0;
    logic [LMCS_DW-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [LMCS_DW-1:0] rdata;
    lmcs_adc_s adc;
    logic tx_dis = 1'b1;
    logic [LMCS_NDET-1:0] det_fault;
    logic bias_settled;
    logic [LMCS_TW-1:0] mod_dac_value;
    logic laser_on;
    logic laser_supply_switch;
    logic tx_fault;
    logic [LMCS_TW-1:0] bias_lvl = 12'h400;
    logic [LMCS_TW-1:0] tint_lvl = 12'h800;
    logic [LMCS_TW-1:0] text_lvl = 12'h800;
    logic [LMCS_NDET-1:0] fault_inj = '0;
    logic slow = 1'b0;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [15:0] v;

    always #4 clk = ~clk;

    lmcs_top #(.ONESHOT_CYC(ONESHOT), .SAMPLE_CYC(4)) dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .adc(adc), .tx_dis(tx_dis), .det_fault(det_fault),
        .bias_settled(bias_settled), .mod_dac_value(mod_dac_value), .laser_on(laser_on),
        .laser_supply_switch(laser_supply_switch), .tx_fault(tx_fault));

    lmcs_laser_model model (.clk(clk), .rst(rst), .tx_dis(tx_dis), .laser_on(laser_on),
        .mod_dac_value(mod_dac_value), .adc(adc), .det_fault(det_fault), .bias_settled(bias_settled),
        .bias_lvl(bias_lvl), .tint_lvl(tint_lvl), .text_lvl(text_lvl), .fault_inj(fault_inj), .slow(slow));

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic dac(input logic [11:0] e);
        cyc(4);
        chk("dac", {4'h0, mod_dac_value}, {4'h0, e});
    endtask

    task automatic outs(input logic on, input logic sw, input logic flt);
        chk("laser_on", {15'h0, laser_on}, {15'h0, on});
        chk("supply", {15'h0, laser_supply_switch}, {15'h0, sw});
        chk("tx_fault", {15'h0, tx_fault}, {15'h0, flt});
    endtask

    task automatic set_dis(input logic d, input int n);
        @(posedge clk);
        tx_dis <= d;
        cyc(n);
    endtask

    task automatic t_power_up;
        rd_reg(LMCS_OFS_COMP_CTL, v);
        chk("comp_ctl", v, LMCS_RST_COMP_CTL);
        rd_reg(LMCS_OFS_MOD_CEIL, v);
        chk("ceiling", v, LMCS_RST_CEIL);
        outs(1'b0, 1'b0, 1'b0);
        set_dis(1'b0, 8);
        outs(1'b0, 1'b0, 1'b0);
        cyc(T_ON);
        outs(1'b1, 1'b1, 1'b0);
    endtask

    task automatic t_compensation;
        wr_reg(LMCS_OFS_COMP_CTL, 16'h0000);
        wr_reg(LMCS_OFS_MOD_TARGET, 16'h0123);
        dac(12'h123);
        rd_reg(LMCS_OFS_DAC, v);
        chk("dac_reg", v, 16'h0123);
        wr_reg(LMCS_OFS_MOD_TARGET, 16'h0100);
        wr_reg(LMCS_OFS_KNEE, 16'h0800);
        wr_reg(LMCS_OFS_SLOPE, 16'h0002);
        tint_lvl <= 12'h7f0;
        text_lvl <= 12'h810;
        wr_reg(LMCS_OFS_COMP_CTL, 16'h0003);
        dac(12'h140);
        wr_reg(LMCS_OFS_COMP_CTL, 16'h0007);
        dac(12'h0c0);
        wr_reg(LMCS_OFS_SLOPE, 16'h001e);
        dac(12'h0fc);
        wr_reg(LMCS_OFS_SLOPE, 16'h0002);
        rd_reg(LMCS_OFS_TEMP_MON, v);
        chk("temp_mon", v, 16'h0810);
        wr_reg(LMCS_OFS_COMP_CTL, 16'h0003);
        tint_lvl <= 12'h900;
        dac(12'h000);
        tint_lvl <= 12'h7ff;
        wr_reg(LMCS_OFS_MOD_TARGET, 16'h0000);
        wr_reg(LMCS_OFS_SLOPE, 16'h000c);
        dac(12'h800);
        wr_reg(LMCS_OFS_MOD_TARGET, 16'h0900);
        dac(12'hfff);
        wr_reg(LMCS_OFS_MOD_TARGET, 16'h0100);
        wr_reg(LMCS_OFS_FW_COEF, 16'h0020);
        wr_reg(LMCS_OFS_COMP_CTL, 16'h000b);
        dac(12'h120);
        wr_reg(LMCS_OFS_FW_COEF, 16'hffe0);
        dac(12'h0e0);
        wr_reg(LMCS_OFS_BIAS_REF, 16'h0400);
        wr_reg(LMCS_OFS_BIAS_GAIN, 16'h0032);
        bias_lvl <= 12'h500;
        wr_reg(LMCS_OFS_COMP_CTL, 16'h0001);
        cyc(20);
        dac(12'h180);
        bias_lvl <= 12'h300;
        cyc(20);
        dac(12'h080);
        rd_reg(LMCS_OFS_BIAS_READING, v);
        chk("bias_reading", v, 16'h0300);
        rd_reg(LMCS_OFS_PWR_MON, v);
        chk("pwr_mon", v, 16'h0180);
        rd_reg(LMCS_OFS_MOD_READING, v);
        chk("mod_reading", v, 16'h0080);
    endtask

    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(LMCS_OFS_MOD_TARGET, 16'h0200);
        cyc(4);
        chk("frozen_dac", {4'h0, mod_dac_value}, 16'h0080);
        @(posedge clk);
        ce <= 1'b1;
        dac(12'h080);
        rd_reg(LMCS_OFS_MOD_TARGET, v);
        chk("target", v, 16'h0100);
    endtask

    task automatic t_fault_latch;
        fault_inj <= 5'h08;
        cyc(6);
        outs(1'b0, 1'b0, 1'b1);
        rd_reg(LMCS_OFS_STATUS, v);
        chk("status", v & 16'h003f, 16'h0028);
        fault_inj <= 5'h00;
        cyc(6);
        outs(1'b0, 1'b0, 1'b1);
        set_dis(1'b1, 4);
        set_dis(1'b0, T_ON);
        outs(1'b1, 1'b1, 1'b0);
        wr_reg(LMCS_OFS_LD_CTL0, 16'h0001);
        cyc(6);
        outs(1'b0, 1'b0, 1'b0);
        wr_reg(LMCS_OFS_LD_CTL0, 16'h0000);
        cyc(T_ON);
        outs(1'b1, 1'b1, 1'b0);
    endtask

    task automatic t_bypass;
        wr_reg(LMCS_OFS_LD_CTL0, 16'h0002);
        fault_inj <= 5'h01;
        cyc(6);
        chk("tx_fault", {15'h0, tx_fault}, 16'h0001);
        chk("laser_on", {15'h0, laser_on}, 16'h0001);
        fault_inj <= 5'h00;
        cyc(6);
        chk("tx_fault", {15'h0, tx_fault}, 16'h0001);
        wr_reg(LMCS_OFS_LD_CTL1, 16'h0001);
        cyc(4);
        outs(1'b1, 1'b1, 1'b0);
        wr_reg(LMCS_OFS_LD_CTL1, 16'h0002);
        fault_inj <= 5'h10;
        cyc(6);
        chk("tx_fault", {15'h0, tx_fault}, 16'h0001);
        fault_inj <= 5'h00;
        cyc(6);
        chk("tx_fault", {15'h0, tx_fault}, 16'h0000);
        wr_reg(LMCS_OFS_LD_CTL1, 16'h0000);
        wr_reg(LMCS_OFS_LD_CTL0, 16'h0000);
    endtask

    task automatic t_enable_checks;
        set_dis(1'b1, 4);
        fault_inj <= 5'h02;
        set_dis(1'b0, 6);
        chk("tx_fault", {15'h0, tx_fault}, 16'h0001);
        fault_inj <= 5'h00;
        cyc(T_ON);
        outs(1'b0, 1'b0, 1'b1);
        set_dis(1'b1, 4);
        slow <= 1'b1;
        set_dis(1'b0, T_ON);
        outs(1'b0, 1'b0, 1'b1);
        slow <= 1'b0;
    endtask

    task automatic t_power_cycle;
        @(posedge clk);
        rst <= 1'b1;
        cyc(2);
        outs(1'b0, 1'b0, 1'b0);
        @(posedge clk);
        rst <= 1'b0;
        cyc(2);
        rd_reg(LMCS_OFS_STATUS, v);
        chk("status", v & 16'h003f, 16'h0000);
    endtask

    task automatic wrap_up;
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_power_up();
        t_compensation();
        t_freeze();
        t_fault_latch();
        t_bypass();
        t_enable_checks();
        t_power_cycle();
        wrap_up();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
endmodule // lmcs_top_tb
